// *** logic/spd_pkg.sv ***
package spd_pkg;
    // Byte addresses of the 24-bit divider register, most significant byte first
    localparam logic [7:0] ADDR_DIV_HI = 8'h89;
    localparam logic [7:0] ADDR_DIV_MID = 8'h8A;
    localparam logic [7:0] ADDR_DIV_LO = 8'h8B;
    localparam logic [23:0] DIV_RESET = 24'h000040;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
    // Field layout
    localparam int MODE_MSB = 23;
    localparam int MODE_LSB = 20;
    localparam int TYPE_BIT = 19;
    localparam int POL_BIT = 18;
    localparam int SEL_MSB = 17;
    localparam int SEL_LSB = 16;
    localparam int PERIOD_MSB = 15;
    // Byte lane boundaries of the register access port
    localparam int BYTE_MID_LSB = 8;
    localparam int BYTE_LO_MSB = 7;
    localparam logic [3:0] MODE_FRAME = 4'hF;
    localparam logic [1:0] SEL_DIV_C = 2'h2;
    localparam logic [23:0] DIV_MAX = 24'hEFFFFF;
    localparam logic [23:0] DIV_MIN = 24'h000002;
    localparam logic [15:0] PERIOD_ONE = 16'h0001;
endpackage

// *** logic/spd_post_div_d.sv ***
// Summary of operation
// - Mode nibble all ones gives frame pulses; otherwise it is the ratio's top bits.
// - Frame mode: bit 18 low gives normal polarity, high gives inverted polarity.
// - Frame mode: bit 19 low centres boundary in pulse, high puts it at edge.
// - Frame mode: low 16 bits count related-clock periods between pulses.
// - Normal mode: whole 24-bit value divides the clock, about half high.
// - Odd ratios near top frequency may give duty outside 45 to 55 percent.
// - Even ratios keep the duty cycle between 45 and 55 percent.
// - Frame mode: select code 10 picks sibling divider C; other codes reserved.
// - Each frame pulse is exactly one related-clock period wide, except that a period of 1 holds the pulse on.
`timescale 1ns/1ps
`default_nettype none
module spd_post_div_d
    import spd_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Register access port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Related clock from sibling divider C
    input wire logic sibling_divider_c_clock_i,
    // Divided clock or frame pulse
    output logic clk_o
);
    import spd_pkg::*;

    logic [23:0] divider_d_value_q;
    logic [23:0] divider_d_value_d;
    logic cfg_chg_q;
    logic [23:0] cnt_q;
    logic [15:0] fcnt_q;
    logic pulse_q;
    logic s1_q, s2_q, s3_q, lvl_q;
    logic agree, rise, fall;
    logic frm_mode, frm_valid, ptype, pol;
    logic [23:0] n_eff, hi_len;
    logic [15:0] period;

    assign frm_mode = divider_d_value_q[MODE_MSB:MODE_LSB] == MODE_FRAME;
    assign ptype = divider_d_value_q[TYPE_BIT];
    assign pol = divider_d_value_q[POL_BIT];
    assign period = divider_d_value_q[PERIOD_MSB:0];
    // Reserved selects and a zero period leave the output idle
    assign frm_valid = frm_mode && (divider_d_value_q[SEL_MSB:SEL_LSB] == SEL_DIV_C)
        && (period != '0);
    // Ratios 0 and 1 cannot be made from a registered output; they act as 2
    assign n_eff = (divider_d_value_q < DIV_MIN) ? DIV_MIN : divider_d_value_q;
    // High phase is the larger half, so even ratios come out at exactly 50%
    assign hi_len = n_eff - (n_eff >> 1);

    always_comb
    begin
        divider_d_value_d = divider_d_value_q;
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                ADDR_DIV_HI: divider_d_value_d[MODE_MSB:SEL_LSB] = reg_wdata_i;
                ADDR_DIV_MID: divider_d_value_d[PERIOD_MSB:BYTE_MID_LSB] = reg_wdata_i;
                ADDR_DIV_LO: divider_d_value_d[BYTE_LO_MSB:0] = reg_wdata_i;
                default: divider_d_value_d = divider_d_value_q;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            divider_d_value_q <= DIV_RESET;
            cfg_chg_q <= 1'b0;
        end
        else
        begin
            divider_d_value_q <= divider_d_value_d;
            cfg_chg_q <= divider_d_value_d != divider_d_value_q;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            reg_rdata_o <= RDATA_UNMAPPED;
        else if (reg_rd_i)
        begin
            case (reg_addr_i)
                ADDR_DIV_HI: reg_rdata_o <= divider_d_value_q[MODE_MSB:SEL_LSB];
                ADDR_DIV_MID: reg_rdata_o <= divider_d_value_q[PERIOD_MSB:BYTE_MID_LSB];
                ADDR_DIV_LO: reg_rdata_o <= divider_d_value_q[BYTE_LO_MSB:0];
                default: reg_rdata_o <= RDATA_UNMAPPED;
            endcase
        end
    end

    // Related clock synchroniser; an edge counts once stages two and three agree
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            lvl_q <= 1'b0;
        end
        else
        begin
            s1_q <= sibling_divider_c_clock_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (agree)
                lvl_q <= s3_q;
        end
    end
    assign agree = s2_q == s3_q;
    assign rise = agree && s3_q && !lvl_q;
    assign fall = agree && !s3_q && lvl_q;

    // Normal-mode divider counter
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            cnt_q <= '0;
        else if (cfg_chg_q || frm_mode || cnt_q >= n_eff - 24'h000001)
            cnt_q <= '0;
        else
            cnt_q <= cnt_q + 24'h000001;
    end

    // Frame counter advances on related-clock rising edges; zero is the boundary
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            fcnt_q <= '0;
        else if (cfg_chg_q || !frm_valid)
            fcnt_q <= '0;
        else if (rise)
            fcnt_q <= (fcnt_q >= period - PERIOD_ONE) ? '0 : fcnt_q + PERIOD_ONE;
    end

    // Pulse spans one related period: edge type from boundary to next rise,
    // centred type from the fall before the boundary to the fall after it
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            pulse_q <= 1'b0;
        else if (cfg_chg_q || !frm_valid)
            pulse_q <= 1'b0;
        else if (ptype && rise)
            pulse_q <= fcnt_q >= period - PERIOD_ONE;
        else if (!ptype && fall)
        begin
            if (fcnt_q == period - PERIOD_ONE)
                pulse_q <= 1'b1;
            else if (fcnt_q == '0)
                pulse_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            clk_o <= 1'b0;
        else if (frm_mode)
            clk_o <= pulse_q ^ pol;
        else
            clk_o <= cnt_q < hi_len;
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    sequence s_frame_boundary;
        frm_valid && !cfg_chg_q && rise && fcnt_q == period - PERIOD_ONE;
    endsequence

    property p_restart;
        cfg_chg_q |-> ##1 (cnt_q == '0 && fcnt_q == '0);
    endproperty
    a_restart: assert property (p_restart) else $error("counters not restarted");

    property p_norm_high;
        !frm_mode && !cfg_chg_q && cnt_q < hi_len |=> clk_o;
    endproperty
    a_norm_high: assert property (p_norm_high) else $error("high phase lost");

    property p_norm_low;
        !frm_mode && cnt_q >= hi_len |=> !clk_o;
    endproperty
    a_norm_low: assert property (p_norm_low) else $error("low phase lost");

    property p_even_half;
        !frm_mode && !n_eff[0] |-> (hi_len << 1) == n_eff;
    endproperty
    a_even_half: assert property (p_even_half) else $error("even ratio not half");

    property p_frame_wrap;
        s_frame_boundary |=> fcnt_q == '0;
    endproperty
    a_frame_wrap: assert property (p_frame_wrap) else $error("frame period wrong");

    property p_edge_start;
        s_frame_boundary ##0 ptype |=> pulse_q;
    endproperty
    a_edge_start: assert property (p_edge_start) else $error("edge pulse missing");

    property p_width_hold;
        frm_valid && !cfg_chg_q && pulse_q && ptype && !rise && period != PERIOD_ONE
            |=> pulse_q;
    endproperty
    a_width_hold: assert property (p_width_hold) else $error("pulse cut short");

    property p_polarity;
        // Polarity is the one in force when the output was launched
        frm_mode && !cfg_chg_q |=> clk_o == ($past(pulse_q) ^ $past(pol));
    endproperty
    a_polarity: assert property (p_polarity) else $error("polarity wrong");

    property p_reserved_idle;
        frm_mode && !frm_valid ##1 frm_mode && !frm_valid |=> clk_o == $past(pol);
    endproperty
    a_reserved_idle: assert property (p_reserved_idle) else $error("reserved not idle");
endmodule
`default_nettype wire

// *** testbench/tb_spd_post_div_d.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_spd_post_div_d;
    import spd_pkg::*;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [7:0] reg_rdata_o;
    logic sibling_divider_c_clock_i = 1'b0;
    logic clk_o;
    logic [3:0] rel_cnt = 4'h0;
    logic [7:0] rd;
    logic [7:0] tbl [3] = '{8'hFA, 8'hF2, 8'hFE};
    logic [7:0] rat [4] = '{8'h07, 8'h04, 8'h0A, 8'h08};
    int n_fail = 0;
    int checks = 0;
    int hi;
    int per;
    int bad;

    spd_post_div_d DUT (.clk_i(clk_i), .nrst_i(nrst_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .sibling_divider_c_clock_i(sibling_divider_c_clock_i),
        .clk_o(clk_o));

    initial
    begin
        forever #12.5 clk_i = ~clk_i;
    end

    // Related clock of 16 cycles, phase-locked so the synchroniser delay is constant
    // It is a separate source, never the block's own output
    always @(posedge clk_i)
    begin
        rel_cnt <= rel_cnt + 4'h1;
        sibling_divider_c_clock_i <= rel_cnt[3];
    end

    task automatic report_and_stop();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        @(negedge clk_i);
        d = reg_rdata_o;
    endtask

    task automatic wait_lvl(input logic v);
        int n;
        n = 0;
        while (clk_o !== v && n < 2000)
        begin
            @(negedge clk_i);
            n++;
        end
    endtask

    // Skips one pulse so a restart transient is never measured
    task automatic measure(input logic act, output int h, output int p);
        wait_lvl(~act);
        wait_lvl(act);
        wait_lvl(~act);
        wait_lvl(act);
        h = 0;
        while (clk_o === act && h < 2000)
        begin
            @(negedge clk_i);
            h++;
        end
        p = h;
        while (clk_o !== act && p < 4000)
        begin
            @(negedge clk_i);
            p++;
        end
    endtask

    initial
    begin
        repeat (50000) @(posedge clk_i);
        n_fail++;
        report_and_stop();
    end

    initial
    begin
        repeat (12) @(posedge clk_i);
        nrst_i <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            rd_reg(ADDR_DIV_HI + 8'(i), rd);
            check("reset byte", 32'(rd), 32'(DIV_RESET[23 - 8 * i -: 8]));
        end
        wr(8'h8C, 8'h5A);
        rd_reg(8'h8C, rd);
        check("unmapped read", 32'(rd), 32'(RDATA_UNMAPPED));
        measure(1'b1, hi, per);
        check("high of 64", 32'(hi), 32'd32);
        check("period of 64", 32'(per), 32'd64);
        for (int i = 0; i < 4; i++)
        begin
            wr(ADDR_DIV_LO, rat[i]);
            rd_reg(ADDR_DIV_LO, rd);
            check("ratio readback", 32'(rd), 32'(rat[i]));
            measure(1'b1, hi, per);
            check("ratio high", 32'(hi), 32'(rat[i] - rat[i] / 2));
            check("ratio period", 32'(per), 32'(rat[i]));
        end
        wr(ADDR_DIV_MID, 8'h00);
        wr(ADDR_DIV_LO, 8'h03);
        for (int i = 0; i < 3; i++)
        begin
            wr(ADDR_DIV_HI, tbl[i]);
            measure(~tbl[i][2], hi, per);
            check("pulse width", 32'(hi), 32'd16);
            check("frame period", 32'(per), 32'd48);
        end
        for (int i = 0; i < 2; i++)
        begin
            wr(ADDR_DIV_HI, i == 0 ? 8'hFC : 8'hF3);
            repeat (8) @(posedge clk_i);
            bad = 0;
            repeat (100)
            begin
                @(negedge clk_i);
                if (clk_o !== (i == 0)) bad++;
            end
            check("reserved select idle", 32'(bad), 32'd0);
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
